// *** hw/hdlc_auto_pkg.sv ***
package hdlc_auto_pkg;
  // ----------------------------------------
  // frame kinds seen on the receive side
  // ----------------------------------------
  typedef enum logic [2:0] {
    kind_iframe,
    kind_rr,
    kind_rnr,
    kind_rej,
    kind_srej,
    kind_other
  } rx_kind_t;

  // ----------------------------------------
  // supervisory frame kinds; the handler sends only rr and rnr, never rej
  // ----------------------------------------
  typedef enum logic [1:0] {
    sup_rr,
    sup_rnr,
    sup_rej
  } sup_kind_t;

  // ----------------------------------------
  // buffer and sequence widths, poll and c/r bit values
  // ----------------------------------------
  localparam int unsigned seq_width = 7;
  localparam int unsigned word_width = 8;
  localparam logic poll_set = 1'b1;
  localparam logic cr_bit_zero = 1'b0;
endpackage

// *** hw/skid_buffer.sv ***
`timescale 1ns/1ps
module skid_buffer #(
  parameter int unsigned width = 8
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [width-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [width-1:0] o_data
);
  // ----------------------------------------
  // two-entry buffer state
  // ----------------------------------------
  typedef struct packed {
    logic [1:0][width-1:0] mem;
    logic [1:0] count;
    logic rd;
    logic wr;
  } buf_state_t;

  buf_state_t state_reg;
  buf_state_t state_next;
  logic push;
  logic pop;

  // registered ready: a full buffer refuses, so no word is lost under stall
  always_comb begin
    push = i_valid && (state_reg.count != 2'd2);
    pop = (state_reg.count != 2'd0) && i_ready;
    state_next = state_reg;
    if (push) begin
      state_next.mem[state_reg.wr] = i_data;
      state_next.wr = ~state_reg.wr;
    end
    if (pop) begin
      state_next.rd = ~state_reg.rd;
    end
    state_next.count = state_reg.count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_ready = state_reg.count != 2'd2;
  assign o_valid = state_reg.count != 2'd0;
  assign o_data = state_reg.mem[state_reg.rd];
endmodule

// *** hw/hdlc_auto_mode.sv ***
`timescale 1ns/1ps
module hdlc_auto_mode #(
  parameter int unsigned seq_width = hdlc_auto_pkg::seq_width,
  parameter int unsigned word_width = hdlc_auto_pkg::word_width
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_nrm_mode,
  input wire logic i_two_byte_addr,
  input wire logic i_rx_valid,
  input wire hdlc_auto_pkg::rx_kind_t i_rx_kind,
  input wire logic i_rx_poll,
  input wire logic i_rx_cr_bit,
  input wire logic [seq_width-1:0] i_rx_ns,
  input wire logic [seq_width-1:0] i_rx_nr,
  input wire logic [word_width-1:0] i_rx_word,
  input wire logic i_rx_word_valid,
  input wire logic i_rx_word_last,
  input wire logic i_data_pending,
  input wire logic i_timer_expired,
  input wire logic i_reject_wanted,
  input wire logic i_local_busy,
  input wire logic i_transmitter_reset_command,
  input wire logic i_tx_busy,
  output logic o_send_iframe,
  output logic o_send_sup,
  output hdlc_auto_pkg::sup_kind_t o_sup_kind,
  output logic [seq_width-1:0] o_tx_ns,
  output logic [seq_width-1:0] o_tx_nr,
  output logic o_tx_poll_final,
  output logic o_waiting_ack,
  output logic o_timer_recovery,
  output logic o_frame_accepted,
  output logic o_protocol_error_flag,
  output logic o_deliver_valid,
  input wire logic i_deliver_ready,
  output logic [word_width-1:0] o_deliver_word,
  output logic o_rx_stall
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [1:0] {
    st_idle,
    st_wait_ack,
    st_recovery
  } link_state_t;

  typedef struct packed {
    link_state_t link;
    logic vs;
    logic vr;
    logic poll_grant;
    logic ack_owed;
    logic ack_final;
    logic accepting;
    logic send_iframe;
    logic send_sup;
    hdlc_auto_pkg::sup_kind_t sup_kind;
    logic poll_final;
    logic accepted;
    logic proto_err;
    logic waiting;
    logic recovery;
    logic out_valid;
    logic [word_width-1:0] out_word;
    // high exactly while the buffer is full, so it matches what the buffer refuses
    logic stall;
  } ctrl_t;

  ctrl_t state_reg;
  ctrl_t state_next;
  logic buf_ready;
  logic buf_valid;
  logic [word_width-1:0] buf_word;
  logic buf_push;
  logic buf_pop;
  logic take_word;

  // a word is taken only on an edge that sees the stall low
  assign buf_push = i_rx_word_valid && state_reg.accepting && !state_reg.stall;
  // output stage pulls when empty or being drained
  assign take_word = !state_reg.out_valid || i_deliver_ready;
  assign buf_pop = buf_valid && take_word;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // window of one: only bit 0 matters
  function automatic logic seq_match(input logic [seq_width-1:0] num, input logic var_bit);
    seq_match = num[0] == var_bit;
  endfunction

  // reject and selective reject fold into receive-ready
  function automatic logic is_ack_kind(input hdlc_auto_pkg::rx_kind_t k);
    is_ack_kind = (k == hdlc_auto_pkg::kind_rr) || (k == hdlc_auto_pkg::kind_rej) ||
      (k == hdlc_auto_pkg::kind_srej) || (k == hdlc_auto_pkg::kind_rnr);
  endfunction

  logic frame_has_nr;
  logic nr_ok;
  logic nr_updated;
  logic is_i;

  always_comb begin
    state_next = state_reg;
    state_next.send_iframe = 1'b0;
    state_next.send_sup = 1'b0;
    state_next.accepted = 1'b0;
    state_next.proto_err = 1'b0;
    is_i = i_rx_valid && (i_rx_kind == hdlc_auto_pkg::kind_iframe);
    frame_has_nr = is_i || (i_rx_valid && is_ack_kind(i_rx_kind));
    // acknowledges own I-frame when n(r) equals our v(s) + 1 (lsb only)
    nr_updated = state_reg.link != st_idle && seq_match(i_rx_nr, ~state_reg.vs);
    nr_ok = nr_updated || seq_match(i_rx_nr, state_reg.vs);
    // ----------------------------------------
    // receive side
    // ----------------------------------------
    if (is_i && !nr_ok) begin
      state_next.proto_err = 1'b1;
      state_next.accepting = 1'b0;
    end else if (is_i) begin
      // c/r bit zero with two-byte address is simply not checked
      state_next.accepted = 1'b1;
      state_next.accepting = seq_match(i_rx_ns, state_reg.vr) && !i_local_busy;
      if (seq_match(i_rx_ns, state_reg.vr) && !i_local_busy) begin
        state_next.vr = ~state_reg.vr;
      end
      state_next.ack_owed = 1'b1;
      state_next.ack_final = i_rx_poll;
      // poll clear: acknowledge only, own data held back in nrm mode
      state_next.poll_grant = state_reg.poll_grant || (i_rx_poll == hdlc_auto_pkg::poll_set);
    end else if (i_rx_valid && is_ack_kind(i_rx_kind) && i_rx_poll) begin
      state_next.poll_grant = 1'b1;
    end
    if (frame_has_nr && nr_ok && nr_updated) begin
      state_next.link = st_idle;
      state_next.vs = ~state_reg.vs;
    end else if (state_reg.link == st_wait_ack && i_timer_expired) begin
      state_next.link = st_recovery;
    end
    // ----------------------------------------
    // transmit side
    // ----------------------------------------
    if (i_transmitter_reset_command) begin
      state_next.link = st_idle;
      state_next.ack_owed = 1'b0;
    end else if (!i_tx_busy && !state_reg.send_iframe && !state_reg.send_sup &&
        state_next.link == st_idle) begin
      if (i_data_pending && (!i_nrm_mode || state_next.poll_grant)) begin
        state_next.send_iframe = 1'b1;
        state_next.poll_final = state_next.ack_final;
        state_next.link = st_wait_ack;
        state_next.ack_owed = 1'b0;
        state_next.ack_final = 1'b0;
        state_next.poll_grant = 1'b0;
      end else if (state_next.ack_owed) begin
        state_next.send_sup = 1'b1;
        // reject request downgraded; busy turns it into not-ready
        state_next.sup_kind = i_local_busy ? hdlc_auto_pkg::sup_rnr : hdlc_auto_pkg::sup_rr;
        state_next.poll_final = state_next.ack_final;
        state_next.ack_owed = 1'b0;
        state_next.ack_final = 1'b0;
        state_next.poll_grant = 1'b0;
      end
    end
    if (i_rx_word_valid && i_rx_word_last && !state_reg.stall) begin
      state_next.accepting = 1'b0;
    end
    state_next.waiting = state_next.link != st_idle;
    state_next.recovery = state_next.link == st_recovery;
    // ----------------------------------------
    // delivery output stage
    // ----------------------------------------
    if (take_word) begin
      state_next.out_valid = buf_valid;
      state_next.out_word = buf_word;
    end
    // stall tracks next occupancy; a lagging copy would drop or double words
    state_next.stall = (!buf_ready && !buf_pop) || (buf_valid && buf_ready && buf_push && !buf_pop);
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // delivery path
  // ----------------------------------------
  // words of a discarded frame never enter the buffer
  skid_buffer #(
    .width(word_width)
  ) u_buf (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_valid(buf_push),
    .o_ready(buf_ready),
    .i_data(i_rx_word),
    .o_valid(buf_valid),
    .i_ready(take_word),
    .o_data(buf_word)
  );

  assign o_deliver_valid = state_reg.out_valid;
  assign o_deliver_word = state_reg.out_word;
  assign o_rx_stall = state_reg.stall;
  assign o_send_iframe = state_reg.send_iframe;
  assign o_send_sup = state_reg.send_sup;
  assign o_sup_kind = state_reg.sup_kind;
  assign o_tx_ns = {{(seq_width-1){1'b0}}, state_reg.vs};
  assign o_tx_nr = {{(seq_width-1){1'b0}}, state_reg.vr};
  assign o_tx_poll_final = state_reg.poll_final;
  assign o_waiting_ack = state_reg.waiting;
  assign o_timer_recovery = state_reg.recovery;
  assign o_frame_accepted = state_reg.accepted;
  assign o_protocol_error_flag = state_reg.proto_err;
endmodule

// *** test/hdlc_auto_mode_sva.sv ***
`timescale 1ns/1ps
module hdlc_auto_mode_sva (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_nrm_mode,
  input wire logic i_rx_valid,
  input wire hdlc_auto_pkg::rx_kind_t i_rx_kind,
  input wire logic i_rx_poll,
  input wire logic i_transmitter_reset_command,
  input wire logic o_send_iframe,
  input wire logic o_send_sup,
  input wire hdlc_auto_pkg::sup_kind_t o_sup_kind,
  input wire logic o_waiting_ack,
  input wire logic o_frame_accepted,
  input wire logic o_protocol_error_flag
);
  // ----
  // handler checks
  // ----
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  chk_no_reject: assert property (o_send_sup |-> o_sup_kind != hdlc_auto_pkg::sup_rej)
    else $error("reject frame sent");
  chk_err_not_acc: assert property (o_protocol_error_flag |-> !o_frame_accepted)
    else $error("errored frame accepted");
  chk_err_cause: assert property (o_protocol_error_flag |->
    $past(i_rx_valid) && $past(i_rx_kind) == hdlc_auto_pkg::kind_iframe) else $error("error without i-frame");
  chk_send_gap: assert property (o_send_iframe |=> !o_send_iframe && !o_send_sup)
    else $error("frame right after i-frame");
  chk_reset_clear: assert property (i_transmitter_reset_command |=> !o_waiting_ack)
    else $error("wait kept after reset command");
  chk_poll_quiet: assert property (i_rx_valid && i_nrm_mode && !i_rx_poll && !o_waiting_ack &&
    i_rx_kind == hdlc_auto_pkg::kind_iframe |=> !o_send_iframe) else $error("data sent without poll");
  chk_rej_plain: assert property (i_rx_valid && i_rx_kind inside {hdlc_auto_pkg::kind_rej,
    hdlc_auto_pkg::kind_srej} |=> !o_protocol_error_flag) else $error("reject raised error");
  chk_acc_cause: assert property (o_frame_accepted |-> $past(i_rx_valid))
    else $error("accept without header");
endmodule
bind hdlc_auto_mode hdlc_auto_mode_sva u_hdlc_auto_mode_sva (.*);

// *** test/remote_station.sv ***
`timescale 1ns/1ps
module remote_station (
  input wire logic i_clock,
  input wire logic i_rx_stall,
  output logic o_valid,
  output hdlc_auto_pkg::rx_kind_t o_kind,
  output logic o_poll,
  output logic o_cr,
  output logic [6:0] o_ns,
  output logic [6:0] o_nr,
  output logic [7:0] o_word,
  output logic o_word_valid,
  output logic o_last
);
  // ----
  // far station
  // ----
  int seed = 32'h78387a9b;
  logic [7:0] sent_q[$];
  initial begin
    {o_valid, o_poll, o_cr, o_ns, o_nr, o_word, o_word_valid, o_last} = '0;
    o_kind = hdlc_auto_pkg::kind_other;
  end
  task automatic hdr(input hdlc_auto_pkg::rx_kind_t k, input logic p, input logic [6:0] ns, input logic [6:0] nr);
    @(posedge i_clock);
    o_valid <= 1;
    o_kind <= k;
    o_poll <= p;
    o_cr <= 0;
    o_ns <= ns;
    o_nr <= nr;
    @(posedge i_clock);
    o_valid <= 0;
    // stale header fields inverted so nothing leans on old values
    o_poll <= ~p;
    o_ns <= ~ns;
    o_nr <= ~nr;
    o_cr <= 1;
  endtask
  task automatic words(input int nw, input bit keep);
    logic [7:0] w;
    @(posedge i_clock);
    for (int i = 0; i < nw; i++) begin
      w = 8'($random(seed));
      o_word_valid <= 1;
      o_word <= w;
      o_last <= (i == nw - 1);
      if (keep) sent_q.push_back(w);
      // word held until an edge that sees the stall low; a stuck stall shows as missing words
      @(negedge i_clock);
      for (int t = 0; t < 60 && i_rx_stall; t++) @(negedge i_clock);
      @(posedge i_clock);
    end
    o_word_valid <= 0;
    o_word <= ~o_word;
    o_last <= 0;
  endtask
endmodule

// *** test/hdlc_auto_mode_tb.sv ***
`timescale 1ns/1ps
module hdlc_auto_mode_tb;
  logic i_clock = 0, i_srst = 1, i_nrm_mode = 1, i_two_byte_addr = 1, i_data_pending = 1, i_tx_busy = 0;
  logic i_timer_expired = 0, i_reject_wanted = 0, i_local_busy = 0, i_transmitter_reset_command = 0;
  logic i_deliver_ready = 0, fill = 0, i_rx_valid, i_rx_poll, i_rx_cr_bit, i_rx_word_valid, i_rx_word_last;
  hdlc_auto_pkg::rx_kind_t i_rx_kind;
  logic [6:0] i_rx_ns, i_rx_nr, o_tx_ns, o_tx_nr;
  logic [7:0] i_rx_word, o_deliver_word;
  logic o_send_iframe, o_send_sup, o_tx_poll_final, o_waiting_ack, o_timer_recovery;
  logic o_frame_accepted, o_protocol_error_flag, o_deliver_valid, o_rx_stall, saw_stall = 0;
  hdlc_auto_pkg::sup_kind_t o_sup_kind;
  int n_mismatch = 0, num_checks = 0, seed = 32'h78387a9b;
  bit vs = 0, vr = 0, wait_ack = 0, tr = 0;
  always #50 i_clock = ~i_clock;
  hdlc_auto_mode u_hdlc_auto_mode (.*);
  remote_station u_remote_station (.i_clock, .i_rx_stall(o_rx_stall), .o_valid(i_rx_valid), .o_kind(i_rx_kind),
    .o_poll(i_rx_poll), .o_cr(i_rx_cr_bit), .o_ns(i_rx_ns), .o_nr(i_rx_nr), .o_word(i_rx_word),
    .o_word_valid(i_rx_word_valid), .o_last(i_rx_word_last));
  // ----
  // checking
  // ----
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge i_clock) i_deliver_ready <= fill ? 1'b0 : 1'($random(seed));
  always @(posedge i_clock) if (o_rx_stall === 1'b1) saw_stall <= 1;
  always @(posedge i_clock) if (o_deliver_valid === 1'b1 && i_deliver_ready) begin
    if (u_remote_station.sent_q.size() == 0) check("extra word", 1, 0);
    else check("word", o_deliver_word, u_remote_station.sent_q.pop_front());
  end
  function automatic logic [6:0] r(input logic b);
    return {6'($random(seed)), b};
  endfunction
  // ----
  // frame model: window of one, low bits only
  // ----
  task automatic frame(input hdlc_auto_pkg::rx_kind_t k, input logic p, input logic [6:0] ns,
    input logic [6:0] nr, input int nw);
    bit ifr, bad, iseq, give, ss;
    ifr = k == hdlc_auto_pkg::kind_iframe;
    bad = ifr && !wait_ack && nr[0] != vs;
    iseq = ifr && !bad && ns[0] == vr;
    ss = ifr && !bad && !wait_ack && !p;
    if (wait_ack && nr[0] == vs) begin
      wait_ack = 0;
      tr = 0;
    end
    give = !bad && p && !wait_ack;
    if (iseq) vr = ~vr;
    u_remote_station.hdr(k, p, ns, nr);
    @(negedge i_clock);
    if (iseq || bad) check("accepted", o_frame_accepted, iseq);
    check("error", o_protocol_error_flag, bad);
    check("send i", o_send_iframe, give);
    check("send s", o_send_sup, ss);
    if (ss) check("sup kind", o_sup_kind, hdlc_auto_pkg::sup_rr);
    if (give) check("tx ns", o_tx_ns[0], vs);
    if (give || ss) check("tx nr", o_tx_nr[0], vr);
    if (ifr && (give || ss)) check("final", o_tx_poll_final, p);
    if (give) begin
      vs = ~vs;
      wait_ack = 1;
    end
    @(negedge i_clock);
    check("waiting", o_waiting_ack, wait_ack);
    check("recovery", o_timer_recovery, tr);
    u_remote_station.words(nw, iseq);
    $display("test done: %s", k.name());
  endtask
  initial begin
    repeat (20000) @(posedge i_clock);
    n_mismatch++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge i_clock);
    i_srst <= 0;
    fill <= 1;
    fork begin repeat (14) @(posedge i_clock); fill <= 0; end join_none
    frame(hdlc_auto_pkg::kind_iframe, 0, 7'h00, 7'h00, 4);
    check("stall", saw_stall, 1);
    frame(hdlc_auto_pkg::kind_iframe, 1, r(1), r(0), 2);
    frame(hdlc_auto_pkg::kind_iframe, 1, r(0), r(0), 2);
    @(posedge i_clock) i_timer_expired <= 1;
    @(posedge i_clock) i_timer_expired <= 0;
    tr = 1;
    @(negedge i_clock) check("recovery", o_timer_recovery, tr);
    frame(hdlc_auto_pkg::kind_rej, 1, r(0), r(1), 0);
    frame(hdlc_auto_pkg::kind_srej, 0, r(0), r(0), 0);
    @(posedge i_clock) i_reject_wanted <= 1;
    frame(hdlc_auto_pkg::kind_iframe, 0, r(0), r(0), 2);
    frame(hdlc_auto_pkg::kind_iframe, 0, r(1), r(1), 2);
    frame(hdlc_auto_pkg::kind_iframe, 1, r(1), r(0), 0);
    @(posedge i_clock) i_transmitter_reset_command <= 1;
    @(posedge i_clock) i_transmitter_reset_command <= 0;
    @(negedge i_clock);
    check("waiting", o_waiting_ack, 0);
    for (int t = 0; t < 200 && u_remote_station.sent_q.size() > 0; t++) @(posedge i_clock);
    check("drained", u_remote_station.sent_q.size(), 0);
    finish_test();
  end
endmodule
